// File: src/sdram_precharge_refresh_power.sv
`timescale 1ns/10ps
`default_nettype none
module sdram_precharge_refresh_power
	import sdram_ctl_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// command pins
	input wire sdram_ctl_pkg::command_bus_type cmd,
	// status
	output sdram_ctl_pkg::device_state_type deviceState,
	output logic [3:0] rowOpenMask,
	output logic [12:0] refreshRow,
	output logic refreshPulse,
	output logic buffersEnabled,
	output logic dataLost
);
	import sdram_ctl_pkg::*;

	// ****************
	// decode
	// ****************
	wire command_type command = decode(cmd);
	wire [1:0] bankIndex = {cmd.bankSelectHigh, cmd.bankSelectLow};
	wire allBanks = cmd.address[A10Bit];
	wire isAccess = (command == CmdRead) || (command == CmdWrite);
	logic cke_q;
	device_state_type dev_q, dev_d;
	logic [7:0] devCount_q, devCount_d;
	logic [12:0] row_q, row_d;
	logic pulse_q;
	logic lost_q, lost_d;
	logic [3:0] rowOpen;
	bank_state_type bankState [BankCount];
	bank_event_type bankEvent [BankCount];
	wire anyOpen = |rowOpen;
	wire anyBusy;
	wire normalTaken = (dev_q == DevNormal) && cke_q && cmd.clockEnable;

	// ****************
	// per-bank events
	// ****************
	logic [3:0] busyBits;
	for (genvar b = 0; b < BankCount; b++) begin : g_bank
		wire hit = (bankIndex == 2'(b));
		assign bankEvent[b].begin_ = normalTaken && command == CmdActive && hit;
		assign bankEvent[b].precharge = normalTaken
			&& command == CmdPrecharge && (allBanks || hit);
		assign bankEvent[b].autoPrecharge = normalTaken && isAccess && hit
			&& allBanks;
		assign bankEvent[b].isWrite = normalTaken && command == CmdWrite
			&& hit;
		assign bankEvent[b].access = normalTaken && isAccess && hit;
		assign bankEvent[b].interrupt = normalTaken && isAccess && !hit;
		assign busyBits[b] = bankState[b] == BankReading
			|| bankState[b] == BankWriting;
		sdram_bank_state u_bank (
			.clock(clock),
			.rst(rst),
			.event_(bankEvent[b]),
			.state(bankState[b]),
			.autoPrechargeArmed(),
			.rowOpen(rowOpen[b])
		);
	end
	assign anyBusy = |busyBits;

	// ****************
	// device modes
	// ****************
	always_comb begin
		dev_d = dev_q;
		devCount_d = (devCount_q == 8'h00) ? devCount_q : devCount_q - 8'h01;
		row_d = row_q;
		lost_d = lost_q;
		case (dev_q)
			DevNormal: begin
				if (cke_q && !cmd.clockEnable && command == CmdRefresh
					&& !anyOpen)
					dev_d = DevSelfRefresh;
				else if (cke_q && !cmd.clockEnable && command == CmdTerminate
					&& !anyOpen) begin
					dev_d = DevDeepPowerDown;
					lost_d = 1'b1;
				end else if (cke_q && !cmd.clockEnable && !anyBusy)
					dev_d = DevPowerDown;
				else if (normalTaken && command == CmdRefresh && !anyOpen) begin
					dev_d = DevRefreshing;
					row_d = row_q + 13'h0001;
					devCount_d = 8'(RowCycleTimeCycles - 1);
				end
			end
			DevRefreshing: begin
				// commands ignored until row cycle time passes
				if (devCount_q == 8'h00)
					dev_d = DevNormal;
			end
			DevPowerDown: begin
				if (cmd.clockEnable && (command == CmdNop
					|| command == CmdDeselect))
					dev_d = DevNormal;
			end
			DevSelfRefresh: begin
				if (cmd.clockEnable) begin
					dev_d = DevExitWait;
					devCount_d = 8'(RowCycleTimeCycles - 1);
				end
			end
			DevExitWait: begin
				if (devCount_q == 8'h00)
					dev_d = DevNormal;
			end
			DevDeepPowerDown: begin
				// exit is on clock enable alone; init must follow
				if (cmd.clockEnable)
					dev_d = DevNormal;
			end
			default: dev_d = DevNormal;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			dev_q <= DevNormal;
			devCount_q <= 8'h00;
			row_q <= 13'h0000;
			cke_q <= 1'b1;
			pulse_q <= 1'b0;
			lost_q <= 1'b0;
		end else begin
			dev_q <= dev_d;
			devCount_q <= devCount_d;
			row_q <= row_d;
			cke_q <= cmd.clockEnable;
			pulse_q <= (dev_d == DevRefreshing) && (dev_q == DevNormal);
			lost_q <= lost_d && !(dev_q == DevNormal && normalTaken
				&& command == CmdModeSet);
		end
	end

	logic [3:0] open_q;
	logic buf_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			open_q <= 4'h0;
			buf_q <= 1'b1;
		end else begin
			open_q <= rowOpen;
			buf_q <= dev_d == DevNormal || dev_d == DevRefreshing;
		end
	end

	assign deviceState = dev_q;
	assign rowOpenMask = open_q;
	assign refreshRow = row_q;
	assign refreshPulse = pulse_q;
	assign buffersEnabled = buf_q;
	assign dataLost = lost_q;
endmodule : sdram_precharge_refresh_power
`default_nettype wire

// File: src/sdram_ctl_pkg.sv
// Function
// - precharge closes one bank or all; a10 selects all, bank bits pick one
// - precharged bank is idle; activate before any read or write
// - precharge to a bank with no open row does nothing
// - a10 on read precharges the bank at burst end; on write, one write recovery after burst end
// - read interrupting auto-precharge read starts that bank's precharge
// - write interrupting auto-precharge read starts that bank's precharge
// - interrupted auto-precharge write precharges one write recovery later
// - last write data for old bank is one cycle before interruption
// - refresh row comes from internal counter, address ignored
// - self refresh is refresh encoding with clock enable low
// - clock enable low with no access enters precharge or active power-down
// - power-down exits with clock enable high and nop or deselect
// - deep power-down is terminate encoding with clock enable low
// - commands decode from select, ras, cas and we
package sdram_ctl_pkg;
	// ****************
	// timing
	// ****************
	localparam int ClockPeriodPs = 4000;
	localparam int PrechargePeriodPs = 19000;
	localparam int RowCycleTimePs = 67000;
	localparam int WriteRecoveryPs = 14000;
	localparam int RowToColumnPs = 19000;
	localparam int BurstLength = 4;
	localparam int PrechargePeriodCycles =
		(PrechargePeriodPs + ClockPeriodPs - 1) / ClockPeriodPs;
	localparam int RowCycleTimeCycles =
		(RowCycleTimePs + ClockPeriodPs - 1) / ClockPeriodPs;
	localparam int WriteRecoveryCycles =
		(WriteRecoveryPs + ClockPeriodPs - 1) / ClockPeriodPs;
	localparam int RowToColumnCycles =
		(RowToColumnPs + ClockPeriodPs - 1) / ClockPeriodPs;
	localparam int SelfRefreshExitCycles = 1;
	localparam int RefreshRowBits = 13;
	localparam int BankCount = 4;
	localparam int A10Bit = 10;

	typedef enum logic [8:0] {
		CmdDeselect = 9'h001, CmdNop = 9'h002, CmdActive = 9'h004,
		CmdRefresh = 9'h008, CmdModeSet = 9'h010, CmdPrecharge = 9'h020,
		CmdRead = 9'h040, CmdWrite = 9'h080, CmdTerminate = 9'h100
	} command_type;

	typedef enum logic [6:0] {
		BankIdle = 7'h01, BankActivating = 7'h02, BankActive = 7'h04,
		BankReading = 7'h08, BankWriting = 7'h10, BankPrecharging = 7'h20,
		BankRecovering = 7'h40
	} bank_state_type;

	typedef enum logic [5:0] {
		DevNormal = 6'h01, DevPowerDown = 6'h02, DevSelfRefresh = 6'h04,
		DevDeepPowerDown = 6'h08, DevRefreshing = 6'h10, DevExitWait = 6'h20
	} device_state_type;

	typedef struct packed {
		logic dieSelectN;
		logic rasN;
		logic casN;
		logic weN;
		logic clockEnable;
		logic [12:0] address;
		logic bankSelectHigh;
		logic bankSelectLow;
	} command_bus_type;

	typedef struct packed {
		logic begin_;
		logic precharge;
		logic autoPrecharge;
		logic isWrite;
		logic access;
		logic interrupt;
	} bank_event_type;

	function automatic command_type decode(input command_bus_type c);
		if (c.dieSelectN)
			return CmdDeselect;
		case ({c.rasN, c.casN, c.weN})
			3'h7: return CmdNop;
			3'h3: return CmdActive;
			3'h1: return CmdRefresh;
			3'h0: return CmdModeSet;
			3'h2: return CmdPrecharge;
			3'h5: return CmdRead;
			3'h4: return CmdWrite;
			3'h6: return CmdTerminate;
			default: return CmdNop;
		endcase
	endfunction : decode
endpackage : sdram_ctl_pkg

// File: src/sdram_bank_state.sv
`timescale 1ns/10ps
`default_nettype none
module sdram_bank_state
	import sdram_ctl_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// events for this bank
	input wire bank_event_type event_,
	// state
	output bank_state_type state,
	output logic autoPrechargeArmed,
	output logic rowOpen
);
	bank_state_type state_q, state_d;
	logic [7:0] count_q, count_d;
	logic ap_q, ap_d;
	wire timerDone = (count_q == 8'h00);

	// ****************
	// per-bank machine
	// ****************
	always_comb begin
		state_d = state_q;
		count_d = timerDone ? count_q : count_q - 8'h01;
		ap_d = ap_q;
		case (state_q)
			BankIdle: begin
				if (event_.begin_) begin
					state_d = BankActivating;
					count_d = 8'(RowToColumnCycles - 1);
				end
			end
			BankActivating: begin
				if (timerDone)
					state_d = BankActive;
			end
			BankActive, BankReading, BankWriting: begin
				if (event_.precharge && !ap_q) begin
					state_d = BankPrecharging;
					count_d = 8'(PrechargePeriodCycles - 1);
				end else if (event_.interrupt && ap_q && state_q == BankReading) begin
					state_d = BankPrecharging;
					count_d = 8'(PrechargePeriodCycles - 1);
				end else if (event_.interrupt && ap_q) begin
					state_d = BankRecovering;
					count_d = 8'(WriteRecoveryCycles - 1);
				end else if (event_.autoPrecharge) begin
					state_d = event_.isWrite ? BankWriting : BankReading;
					ap_d = 1'b1;
					count_d = 8'(BurstLength - 1);
				end else if (event_.access) begin
					// plain burst: busy for one burst, then back to active
					state_d = event_.isWrite ? BankWriting : BankReading;
					count_d = 8'(BurstLength - 1);
				end else if (state_q != BankActive && timerDone && !ap_q) begin
					state_d = BankActive;
				end else if (state_q != BankActive && timerDone) begin
					state_d = state_q == BankWriting ? BankRecovering
						: BankPrecharging;
					count_d = state_q == BankWriting
						? 8'(WriteRecoveryCycles - 1)
						: 8'(PrechargePeriodCycles - 1);
				end
			end
			BankRecovering: begin
				if (timerDone) begin
					state_d = BankPrecharging;
					count_d = 8'(PrechargePeriodCycles - 1);
				end
			end
			BankPrecharging: begin
				if (timerDone) begin
					state_d = BankIdle;
					ap_d = 1'b0;
				end
			end
			default: state_d = BankIdle;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= BankIdle;
			count_q <= 8'h00;
			ap_q <= 1'b0;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
			ap_q <= ap_d;
		end
	end

	assign state = state_q;
	assign autoPrechargeArmed = ap_q;
	assign rowOpen = (state_q != BankIdle) && (state_q != BankPrecharging);
endmodule : sdram_bank_state
`default_nettype wire

// File: verification/sdram_precharge_refresh_power_checker.sv
`timescale 1ns/10ps
`default_nettype none
module sdram_precharge_refresh_power_checker
	import sdram_ctl_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// watched pins
	input wire sdram_ctl_pkg::command_bus_type cmd,
	input wire sdram_ctl_pkg::device_state_type deviceState,
	input wire logic [3:0] rowOpenMask,
	input wire logic [12:0] refreshRow,
	input wire logic refreshPulse,
	input wire logic buffersEnabled,
	input wire logic dataLost
);
	// ****
	// properties
	// ****
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire logic taken = cmd.clockEnable && !cmd.dieSelectN &&
		deviceState == DevNormal;
	wire logic [1:0] bank = {cmd.bankSelectHigh, cmd.bankSelectLow};
	wire logic [2:0] rcw = {cmd.rasN, cmd.casN, cmd.weN};
	sequence closeBank0;
		taken && $past(cmd.clockEnable) && rcw == 3'h2 &&
			!cmd.address[10] && bank == 2'h0;
	endsequence
	sequence openBank1;
		taken && $past(cmd.clockEnable) && rcw == 3'h3 && bank == 2'h1;
	endsequence
	a_precharge_close: assert property (
		closeBank0 |-> ##[1:8] !rowOpenMask[0]) else $error("row stayed open");
	a_activate_open: assert property (
		openBank1 |-> ##[1:8] rowOpenMask[1]) else $error("row not opened");
	a_pulse_once: assert property (
		refreshPulse |=> !refreshPulse) else $error("refresh pulse too long");
	a_row_step: assert property (
		refreshRow != $past(refreshRow) |->
		refreshRow == $past(refreshRow) + 13'h1) else $error("row skipped");
	a_refresh_hold: assert property (
		$rose(deviceState == DevRefreshing) |->
		(deviceState == DevRefreshing) [*8]) else $error("refresh cut short");
	a_pd_buffers: assert property (
		deviceState == DevPowerDown |-> !buffersEnabled)
		else $error("buffers on in power-down");
	a_pd_stay: assert property (
		deviceState == DevPowerDown && !cmd.clockEnable |=>
		deviceState == DevPowerDown) else $error("power-down left early");
	a_self_stay: assert property (
		deviceState == DevSelfRefresh && !cmd.clockEnable |=>
		deviceState == DevSelfRefresh) else $error("self refresh left early");
	a_deep_lost: assert property (
		deviceState == DevDeepPowerDown |-> dataLost)
		else $error("data loss not flagged");
	a_deep_exit: assert property (
		deviceState == DevDeepPowerDown && cmd.clockEnable |->
		##[0:3] deviceState == DevNormal) else $error("deep exit missing");
endmodule : sdram_precharge_refresh_power_checker
bind sdram_precharge_refresh_power sdram_precharge_refresh_power_checker chk (
	.clock(clock), .rst(rst), .cmd(cmd), .deviceState(deviceState),
	.rowOpenMask(rowOpenMask), .refreshRow(refreshRow),
	.refreshPulse(refreshPulse), .buffersEnabled(buffersEnabled),
	.dataLost(dataLost));
`default_nettype wire

// File: verification/sdram_controller_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdram_controller_model
	import sdram_ctl_pkg::*;
(
	// clock
	input wire logic clock,
	// command pins
	output logic [19:0] cmd
);
	// ****
	// controller
	// ****
	localparam int RowOpenCycles = (45000 + ClockPeriodPs - 1) / ClockPeriodPs;
	initial cmd = 20'h78000;
	function automatic int gap_for(input logic [2:0] rcw, input logic cke,
		input logic a10);
		case (rcw)
			3'h3: return RowOpenCycles;
			3'h2: return PrechargePeriodCycles;
			3'h1: return RowCycleTimeCycles;
			3'h4, 3'h5: return a10 ? BurstLength + WriteRecoveryCycles +
				PrechargePeriodCycles : BurstLength;
			3'h7: return cke ? RowCycleTimeCycles + SelfRefreshExitCycles : 2;
			default: return 2;
		endcase
	endfunction : gap_for
	// gap 0 keeps the timing; a scenario passes its own gap to break it
	task automatic send(input logic [2:0] rcw, input logic cke,
		input logic [1:0] bank, input logic a10, input int gap);
		int n;
		n = (gap == 0) ? gap_for(rcw, cke, a10) : gap;
		@(posedge clock);
		cmd <= {1'b0, rcw, cke, 2'h0, a10, 10'h155, bank};
		repeat (n) begin
			@(posedge clock);
			cmd[18:16] <= 3'h7;
			// gaps deselect the die, so deselect is exercised as a no-op
			cmd[19] <= 1'b1;
			// address inverts each gap cycle, so it is back to the command's value every second cycle
			cmd[14:2] <= ~cmd[14:2];
		end
	endtask : send
endmodule : sdram_controller_model
`default_nettype wire

// File: verification/test_sdram_precharge_refresh_power.sv
`timescale 1ns/10ps
`default_nettype none
module test_sdram_precharge_refresh_power;
	import sdram_ctl_pkg::*;
	// ****
	// bench
	// ****
	localparam logic [2:0] Act = 3'h3, Pre = 3'h2, Ref = 3'h1, Mrs = 3'h0;
	localparam logic [2:0] Rd = 3'h5, Wr = 3'h4, Nop = 3'h7, Term = 3'h6;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [19:0] cmdBits;
	device_state_type deviceState;
	logic [3:0] rowOpenMask;
	logic [12:0] refreshRow;
	logic refreshPulse, buffersEnabled, dataLost;
	int err_total = 0;
	int tests_run = 0;
	always #2 clock = ~clock;
	sdram_controller_model ctl (.clock(clock), .cmd(cmdBits));
	sdram_precharge_refresh_power uut (.clock(clock), .rst(rst),
		.cmd(command_bus_type'(cmdBits)), .deviceState(deviceState),
		.rowOpenMask(rowOpenMask), .refreshRow(refreshRow),
		.refreshPulse(refreshPulse), .buffersEnabled(buffersEnabled),
		.dataLost(dataLost));
	task automatic check(input logic [15:0] seen, input logic [15:0] expected);
		tests_run++;
		if (seen !== expected) begin
			err_total++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen,
				expected);
		end
	endtask : check
	task automatic go(input logic [2:0] rcw, input logic cke,
		input logic [1:0] bank, input logic a10, input int gap);
		ctl.send(rcw, cke, bank, a10, gap);
		@(negedge clock);
	endtask : go
	task automatic s_reset();
		check(16'(deviceState), 16'(DevNormal));
		check(16'(rowOpenMask), 16'h0);
		check(16'(refreshRow), 16'h0);
		check({refreshPulse, buffersEnabled, dataLost}, 16'h2);
	endtask : s_reset
	task automatic s_precharge();
		go(Act, 1, 0, 0, 0);
		check(16'(rowOpenMask), 16'h1);
		go(Pre, 1, 0, 0, 0);
		check(16'(rowOpenMask), 16'h0);
		go(Act, 1, 2, 0, 0);
		go(Act, 1, 3, 0, 0);
		go(Pre, 1, 0, 1, 0);
		check(16'(rowOpenMask), 16'h0);
		go(Pre, 1, 1, 0, 0);
		check({10'h0, deviceState} | 16'(rowOpenMask), 16'(DevNormal));
	endtask : s_precharge
	task automatic s_autopre();
		go(Act, 1, 1, 0, 0);
		go(Rd, 1, 1, 1, 0);
		check(16'(rowOpenMask), 16'h0);
		go(Act, 1, 2, 0, 0);
		go(Act, 1, 3, 0, 0);
		go(Wr, 1, 2, 1, 1);
		go(Wr, 1, 3, 0, 0);
		go(Nop, 1, 0, 0, PrechargePeriodCycles + WriteRecoveryCycles);
		check(16'(rowOpenMask), 16'h8);
		go(Act, 1, 0, 0, 0);
		go(Rd, 1, 0, 1, 1);
		go(Rd, 1, 3, 0, 0);
		go(Nop, 1, 0, 0, PrechargePeriodCycles);
		check(16'(rowOpenMask), 16'h8);
		go(Act, 1, 1, 0, 0);
		go(Rd, 1, 1, 1, 1);
		go(Wr, 1, 3, 0, 0); // two cycles after the read: room for mask
		go(Nop, 1, 0, 0, PrechargePeriodCycles);
		check(16'(rowOpenMask), 16'h8);
		go(Pre, 1, 0, 1, 0);
	endtask : s_autopre
	task automatic s_refresh();
		logic [12:0] r0;
		r0 = refreshRow;
		go(Ref, 1, 3, 1, 1);
		check({9'h0, refreshPulse, deviceState},
			{9'h0, 1'b1, DevRefreshing});
		go(Ref, 1, 3, 1, 0);
		check(16'(refreshRow), 16'(r0 + 13'h1));
		go(Ref, 1, 0, 0, 0);
		check(16'(refreshRow), 16'(r0 + 13'h2));
	endtask : s_refresh
	task automatic s_power();
		go(Nop, 0, 0, 0, 0);
		check({9'h0, buffersEnabled, deviceState}, 16'(DevPowerDown));
		go(Nop, 1, 0, 0, 0);
		check({9'h0, buffersEnabled, deviceState},
			{9'h0, 1'b1, DevNormal});
		go(Act, 1, 0, 0, 0);
		go(Nop, 0, 0, 0, 0);
		check({rowOpenMask, 6'h0, deviceState}, 16'h1002);
		go(Nop, 1, 0, 0, 0);
		go(Pre, 1, 0, 1, 0);
		go(Ref, 0, 0, 0, 0);
		check(16'(deviceState), 16'(DevSelfRefresh));
		go(Nop, 1, 0, 0, 0);
		check(16'(deviceState), 16'(DevNormal));
		go(Term, 0, 0, 0, 0);
		check({dataLost, 9'h0, deviceState}, 16'h8008);
		go(Nop, 1, 0, 0, 0);
		check({dataLost, 9'h0, deviceState}, 16'h8001);
		go(Mrs, 1, 0, 0, 0);
		check(16'(dataLost), 16'h0);
	endtask : s_power
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	// whole run is a few hundred cycles; this allows about seventy times that
	initial begin
		#100000;
		err_total++;
		summarize();
	end
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		s_reset();
		s_precharge();
		s_autopre();
		s_refresh(); // run is far shorter than one refresh interval
		s_power();
		summarize();
	end
endmodule : test_sdram_precharge_refresh_power
`default_nettype wire
